/* pkg/tccp_pkg.sv */
// Package with constants and carrier types for the test and clock control pin block.
package tccp_pkg;

   // ------------------------------------------------------------
   // Output clock source and divider
   // ------------------------------------------------------------
   localparam logic [3:0] TCCP_DIV_1 = 4'h0;
   localparam logic [3:0] TCCP_DIV_2 = 4'h1;
   localparam logic [3:0] TCCP_DIV_4 = 4'h2;
   localparam logic [3:0] TCCP_DIV_5 = 4'h3;
   localparam logic [3:0] TCCP_DIV_8 = 4'h4;
   localparam logic [3:0] TCCP_DIV_10 = 4'h5;
   localparam logic [3:0] TCCP_DIV_16 = 4'h6;
   localparam logic [3:0] TCCP_DIV_20 = 4'h7;
   localparam logic [3:0] TCCP_DIV_25 = 4'h8;
   localparam logic [4:0] TCCP_RATIO_1 = 5'h01;
   localparam logic [4:0] TCCP_RATIO_2 = 5'h02;
   localparam logic [4:0] TCCP_RATIO_4 = 5'h04;
   localparam logic [4:0] TCCP_RATIO_5 = 5'h05;
   localparam logic [4:0] TCCP_RATIO_8 = 5'h08;
   localparam logic [4:0] TCCP_RATIO_10 = 5'h0A;
   localparam logic [4:0] TCCP_RATIO_16 = 5'h10;
   localparam logic [4:0] TCCP_RATIO_20 = 5'h14;
   localparam logic [4:0] TCCP_RATIO_25 = 5'h19;
   localparam logic [4:0] TCCP_OSC_RATIO = 5'h02;
   localparam logic [4:0] TCCP_CNT_ZERO = 5'h00;
   localparam logic [4:0] TCCP_CNT_ONE = 5'h01;

   // ------------------------------------------------------------
   // Pattern selection and reporting
   // ------------------------------------------------------------
   localparam logic [1:0] TCCP_PAT_31 = 2'h0;
   localparam int TCCP_LS_LANES = 8;
   localparam int TCCP_CHANS = 2;
   localparam int TCCP_CHAN_A = 0;
   localparam int TCCP_CHAN_B = 1;
   localparam int TCCP_SEL_SIDE_BIT = 3;

   typedef enum logic [0:0] {
      TCCP_SRC_BYTE = 1'b0,
      TCCP_SRC_OSC = 1'b1
   } tccp_src_e;

   // Per-channel pattern enable bits, transmit and receive.
   typedef struct packed {
      logic rx_en;
      logic tx_en;
   } tccp_pat_en_s;

   // Per-channel checker status: one high-speed flag and one per low-speed lane.
   typedef struct packed {
      logic [TCCP_LS_LANES-1:0] ls_err;
      logic hs_err;
   } tccp_chk_s;

   // Enables handed to the generators and checkers of one channel.
   typedef struct packed {
      logic hs_tx;
      logic hs_rx;
      logic ls_tx;
      logic ls_rx;
   } tccp_pat_out_s;

endpackage : tccp_pkg

/* rtl/tccp_clk_div.sv */
// Output clock divider with selectable ratio.
`timescale 1ns/1ps
module tccp_clk_div
   import tccp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] ratio_i,
   input wire logic src_tick_i,
   output logic clk_o
);

   logic [4:0] cnt_reg;
   logic [4:0] half;
   logic clk_reg;

   assign half = ratio_i >> 1;

   // ------------------------------------------------------------
   // Divider counter
   // ------------------------------------------------------------
   // Counts source ticks; odd ratios above 1 have a high phase one tick shorter.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_reg <= TCCP_CNT_ZERO;
      end else if (src_tick_i) begin
         if (cnt_reg >= ratio_i - TCCP_CNT_ONE) begin
            cnt_reg <= TCCP_CNT_ZERO;
         end else begin
            cnt_reg <= cnt_reg + TCCP_CNT_ONE;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clk_reg <= 1'b0;
      end else if (ratio_i == TCCP_RATIO_1) begin
         clk_reg <= src_tick_i;
      end else if (src_tick_i) begin
         clk_reg <= (cnt_reg < half);
      end
   end

   assign clk_o = clk_reg;

endmodule : tccp_clk_div

/* rtl/tccp_top.sv */
// Test and clock control pin logic of a two-channel link aggregator.
`timescale 1ns/1ps
// Function
// R1 - Low sleep pin powers down channel B
// R2 - Controller issues datapath reset after wake
// R3 - Select pin picks reference clock zero/one
// R4 - Reference zero default; tie select low
// R5 - Default output: recovered byte clock enabled
// R6 - Option: oscillator clock divided by two
// R7 - Divider ratios 1,2,4,5,8,10,16,20,25 selectable
// R8 - Clock pins zero in reset, float powered down
// R9 - Test pin enables all generators and checkers
// R10 - Channel enable is pin OR register bits
// R11 - Default pattern length 2^31-1, changeable
// R12 - Pass high error free, low on error
// R13 - Four-bit field picks reported checker
// R14 - Pass low in reset, float both down
// R15 - Controller holds reset at least 10us
module tccp_top
   import tccp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chan_a_sleep_low_i,
   input wire logic chan_b_sleep_low_i,
   input wire logic chan_a_reg_down_i,
   input wire logic chan_b_reg_down_i,
   input wire logic ref_clock_choose_i,
   input wire logic chan_a_ref_choose_i,
   input wire logic chan_b_ref_choose_i,
   input wire logic byte_clk_tick_i,
   input wire logic osc_clk_tick_i,
   input wire logic clk_out_disable_i,
   input wire tccp_src_e clk_src_i,
   input wire logic [3:0] clk_div_sel_i,
   input wire logic pattern_test_enable_i,
   input wire tccp_pat_en_s [TCCP_CHANS-1:0] reg_pat_en_i,
   input wire logic [1:0] pat_sel_i,
   input wire tccp_chk_s [TCCP_CHANS-1:0] chk_status_i,
   input wire logic [3:0] pass_sel_i,
   output logic chan_b_power_down_o,
   output logic chan_a_ref_one_o,
   output logic chan_b_ref_one_o,
   output logic chan_a_clock_output_o,
   output logic chan_a_clock_output_oe_o,
   output logic chan_b_clock_output_o,
   output logic chan_b_clock_output_oe_o,
   output tccp_pat_out_s [TCCP_CHANS-1:0] pat_en_o,
   output logic [1:0] pat_sel_o,
   output logic pattern_check_ok_o,
   output logic pattern_check_ok_oe_o
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [4:0] pins;
   logic sleep_a_low;
   logic sleep_b_low;
   logic ref_pin;
   logic pat_pin;
   logic ref_b_pin;

   assign pins = {chan_b_ref_choose_i, pattern_test_enable_i, ref_clock_choose_i,
                  chan_b_sleep_low_i, chan_a_sleep_low_i};

   // Sleep pins reset low so both channels stay down until sampled high.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   assign sleep_a_low = sync2_reg[0];
   assign sleep_b_low = sync2_reg[1];
   assign ref_pin = sync2_reg[2];
   assign pat_pin = sync2_reg[3];
   assign ref_b_pin = sync2_reg[4];

   // ------------------------------------------------------------
   // Power down and reference selection
   // ------------------------------------------------------------
   logic pd_b_reg;
   logic ref_a_reg;
   logic ref_b_reg;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pd_b_reg <= 1'b1;
      end else begin
         pd_b_reg <= !sleep_b_low; // [R1]
      end
   end

   // Reference zero is the reset default; register choice ORs with the pin.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ref_a_reg <= 1'b0; // [R4]
         ref_b_reg <= 1'b0; // [R4]
      end else begin
         ref_a_reg <= ref_pin | chan_a_ref_choose_i; // [R3]
         ref_b_reg <= ref_pin | ref_b_pin; // [R3]
      end
   end

   assign chan_b_power_down_o = pd_b_reg;
   assign chan_a_ref_one_o = ref_a_reg;
   assign chan_b_ref_one_o = ref_b_reg;

   // ------------------------------------------------------------
   // Output clock
   // ------------------------------------------------------------
   logic [4:0] ratio;
   logic [4:0] ratio_eff;
   logic src_tick;
   logic div_clk;
   logic ck_reg;
   logic ck_oe_reg;
   logic down_a;
   logic down_b;
   logic pin_down_both;

   always_comb begin
      unique case (clk_div_sel_i) // [R7]
         TCCP_DIV_1: ratio = TCCP_RATIO_1;
         TCCP_DIV_2: ratio = TCCP_RATIO_2;
         TCCP_DIV_4: ratio = TCCP_RATIO_4;
         TCCP_DIV_5: ratio = TCCP_RATIO_5;
         TCCP_DIV_8: ratio = TCCP_RATIO_8;
         TCCP_DIV_10: ratio = TCCP_RATIO_10;
         TCCP_DIV_16: ratio = TCCP_RATIO_16;
         TCCP_DIV_20: ratio = TCCP_RATIO_20;
         TCCP_DIV_25: ratio = TCCP_RATIO_25;
         default: ratio = TCCP_RATIO_1;
      endcase
   end

   // Byte ticks already run at line rate over 20; the oscillator is halved.
   assign src_tick = (clk_src_i == TCCP_SRC_OSC) ? osc_clk_tick_i : byte_clk_tick_i; // [R5]
   assign ratio_eff = (clk_src_i == TCCP_SRC_OSC) ? TCCP_OSC_RATIO : ratio; // [R6]

   tccp_clk_div u_div (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .ratio_i(ratio_eff),
      .src_tick_i(src_tick),
      .clk_o(div_clk)
   );

   assign down_a = !sleep_a_low | chan_a_reg_down_i;
   assign down_b = !sleep_b_low | chan_b_reg_down_i;
   assign pin_down_both = !sleep_a_low & !sleep_b_low;

   // Driven zero in reset, released while both channels are down or disabled.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ck_reg <= 1'b0; // [R8]
         ck_oe_reg <= 1'b1; // [R8]
      end else begin
         ck_reg <= div_clk; // [R5]
         ck_oe_reg <= !(down_a & down_b) & !clk_out_disable_i; // [R8]
      end
   end

   assign chan_a_clock_output_o = ck_reg;
   assign chan_b_clock_output_o = ck_reg;
   assign chan_a_clock_output_oe_o = ck_oe_reg;
   assign chan_b_clock_output_oe_o = ck_oe_reg;

   // ------------------------------------------------------------
   // Pattern test enables
   // ------------------------------------------------------------
   tccp_pat_out_s [TCCP_CHANS-1:0] pat_reg;
   logic [1:0] psel_reg;

   genvar ch;
   generate
      for (ch = 0; ch < TCCP_CHANS; ch++) begin : g_chan
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               pat_reg[ch] <= '0;
            end else begin
               pat_reg[ch].hs_tx <= pat_pin | reg_pat_en_i[ch].tx_en; // [R9] [R10]
               pat_reg[ch].ls_tx <= pat_pin | reg_pat_en_i[ch].tx_en; // [R9] [R10]
               pat_reg[ch].hs_rx <= pat_pin | reg_pat_en_i[ch].rx_en; // [R9] [R10]
               pat_reg[ch].ls_rx <= pat_pin | reg_pat_en_i[ch].rx_en; // [R9] [R10]
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         psel_reg <= TCCP_PAT_31; // [R11]
      end else begin
         psel_reg <= pat_sel_i; // [R11]
      end
   end

   assign pat_en_o = pat_reg;
   assign pat_sel_o = psel_reg;

   // ------------------------------------------------------------
   // Pass indicator
   // ------------------------------------------------------------
   logic err_pick;
   logic chk_on;
   logic pass_reg;
   logic pass_oe_reg;
   int unsigned chan_idx;

   // Bit 3 picks low-speed side of channel A, bits 2:0 the lane; otherwise bit 2 picks channel B.
   always_comb begin
      chan_idx = pass_sel_i[2] ? TCCP_CHAN_B : TCCP_CHAN_A;
      if (pass_sel_i[TCCP_SEL_SIDE_BIT]) begin
         err_pick = chk_status_i[TCCP_CHAN_A].ls_err[pass_sel_i[2:0]]; // [R13]
      end else begin
         err_pick = chk_status_i[chan_idx].hs_err; // [R13]
      end
      chk_on = pat_reg[chan_idx].hs_rx;
      if (pass_sel_i[TCCP_SEL_SIDE_BIT]) begin
         chk_on = pat_reg[TCCP_CHAN_A].ls_rx;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pass_reg <= 1'b0; // [R14]
         pass_oe_reg <= 1'b1; // [R14]
      end else begin
         pass_reg <= chk_on & !err_pick; // [R12]
         pass_oe_reg <= !pin_down_both; // [R14]
      end
   end

   assign pattern_check_ok_o = pass_reg;
   assign pattern_check_ok_oe_o = pass_oe_reg;

endmodule : tccp_top

/* verif/tccp_tick_src.sv */
// Tick source model for the recovered byte clock and the oscillator clock.
`timescale 1ns/1ps
module tccp_tick_src
   import tccp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   output logic byte_clk_tick_o,
   output logic osc_clk_tick_o
);
   logic [1:0] osc_cnt_reg;
   // Byte tick every 2 cycles and oscillator tick every 3, so the two sources differ.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte_clk_tick_o <= 1'b0;
         osc_cnt_reg <= 2'h0;
      end else begin
         byte_clk_tick_o <= ~byte_clk_tick_o;
         osc_cnt_reg <= (osc_cnt_reg == 2'h2) ? 2'h0 : osc_cnt_reg + 2'h1;
      end
   end
   assign osc_clk_tick_o = (osc_cnt_reg == 2'h2);
endmodule : tccp_tick_src

/* verif/tccp_top_asserts.sv */
// Concurrent checks on the ports of the pin control block.
`timescale 1ns/1ps
module tccp_top_asserts
   import tccp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chan_a_reg_down_i,
   input wire logic chan_b_reg_down_i,
   input wire logic chan_b_sleep_low_i,
   input wire logic ref_clock_choose_i,
   input wire logic chan_a_ref_choose_i,
   input wire logic pattern_test_enable_i,
   input wire tccp_pat_en_s [TCCP_CHANS-1:0] reg_pat_en_i,
   input wire logic [1:0] pat_sel_i,
   input wire tccp_chk_s [TCCP_CHANS-1:0] chk_status_i,
   input wire logic [3:0] pass_sel_i,
   input wire logic chan_b_power_down_o,
   input wire logic chan_a_ref_one_o,
   input wire logic chan_b_ref_one_o,
   input wire logic chan_a_clock_output_oe_o,
   input wire tccp_pat_out_s [TCCP_CHANS-1:0] pat_en_o,
   input wire logic [1:0] pat_sel_o,
   input wire logic pattern_check_ok_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_b_asleep; !chan_b_sleep_low_i [*4]; endsequence
   sequence s_b_awake; (chan_b_sleep_low_i && !chan_b_reg_down_i) [*4]; endsequence
   property p_b_down; s_b_asleep |=> chan_b_power_down_o; endproperty
   a_b_down: assert property (p_b_down) else $error("B not down");
   property p_b_up; s_b_awake |=> !chan_b_power_down_o; endproperty
   a_b_up: assert property (p_b_up) else $error("B still down");
   property p_ref_one; ref_clock_choose_i [*4] |=> chan_a_ref_one_o && chan_b_ref_one_o; endproperty
   a_ref_one: assert property (p_ref_one) else $error("ref one missing");
   property p_ref_zero; (!ref_clock_choose_i && !chan_a_ref_choose_i) [*4] |=> !chan_a_ref_one_o;
   endproperty
   a_ref_zero: assert property (p_ref_zero) else $error("ref zero missing");
   property p_pat_all; pattern_test_enable_i [*4] |=> (pat_en_o == 8'hFF); endproperty
   a_pat_all: assert property (p_pat_all) else $error("pattern enables low");
   property p_pat_off; (!pattern_test_enable_i && reg_pat_en_i == 4'h0) [*4] |=> pat_en_o == 8'h00;
   endproperty
   a_pat_off: assert property (p_pat_off) else $error("pattern enables high");
   property p_pat_sel; $stable(pat_sel_i) |=> pat_sel_o == $past(pat_sel_i); endproperty
   a_pat_sel: assert property (p_pat_sel) else $error("pattern select lost");
   property p_pass_ok;
      (pass_sel_i == 4'h0 && pat_en_o[0].hs_rx && !chk_status_i[0].hs_err) [*2] |=> pattern_check_ok_o;
   endproperty
   a_pass_ok: assert property (p_pass_ok) else $error("pass low");
   property p_pass_err; (pass_sel_i == 4'h0 && chk_status_i[0].hs_err) [*2] |=> !pattern_check_ok_o;
   endproperty
   a_pass_err: assert property (p_pass_err) else $error("pass high");
   property p_float; (chan_a_reg_down_i && chan_b_reg_down_i) [*2] |=> !chan_a_clock_output_oe_o;
   endproperty
   a_float: assert property (p_float) else $error("clock driven");
endmodule : tccp_top_asserts

bind tccp_top tccp_top_asserts u_asserts (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
   .chan_a_reg_down_i(chan_a_reg_down_i), .chan_b_reg_down_i(chan_b_reg_down_i),
   .chan_b_sleep_low_i(chan_b_sleep_low_i), .ref_clock_choose_i(ref_clock_choose_i),
   .chan_a_ref_choose_i(chan_a_ref_choose_i), .pattern_test_enable_i(pattern_test_enable_i),
   .reg_pat_en_i(reg_pat_en_i), .pat_sel_i(pat_sel_i), .chk_status_i(chk_status_i),
   .pass_sel_i(pass_sel_i), .chan_b_power_down_o(chan_b_power_down_o),
   .chan_a_ref_one_o(chan_a_ref_one_o), .chan_b_ref_one_o(chan_b_ref_one_o),
   .chan_a_clock_output_oe_o(chan_a_clock_output_oe_o), .pat_en_o(pat_en_o),
   .pat_sel_o(pat_sel_o), .pattern_check_ok_o(pattern_check_ok_o));

/* verif/tccp_top_tb.sv */
// Self-checking bench for the pin control block.
`timescale 1ns/1ps
module tccp_top_tb
   import tccp_pkg::*;
;
   logic clk, rst_n, byt, osc, a_sl, b_sl, a_rd, b_rd, rsel, a_rc, b_rc, dis, pte;
   logic b_pd, a_r1, b_r1, a_co, a_oe, b_co, b_oe, ok, ok_oe;
   tccp_src_e src;
   logic [3:0] dsel, psel;
   logic [1:0] psi, pso;
   tccp_pat_en_s [TCCP_CHANS-1:0] ren;
   tccp_chk_s [TCCP_CHANS-1:0] chk;
   tccp_pat_out_s [TCCP_CHANS-1:0] pen;
   int fail_count = 0, checked = 0, cyc = 0, p;
   int ratios [10] = '{1, 2, 4, 5, 8, 10, 16, 20, 25, 1};
   tccp_top u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .chan_a_sleep_low_i(a_sl),
      .chan_b_sleep_low_i(b_sl), .chan_a_reg_down_i(a_rd), .chan_b_reg_down_i(b_rd),
      .ref_clock_choose_i(rsel), .chan_a_ref_choose_i(a_rc), .chan_b_ref_choose_i(b_rc),
      .byte_clk_tick_i(byt), .osc_clk_tick_i(osc), .clk_out_disable_i(dis),
      .clk_src_i(src), .clk_div_sel_i(dsel), .pattern_test_enable_i(pte),
      .reg_pat_en_i(ren), .pat_sel_i(psi), .chk_status_i(chk), .pass_sel_i(psel),
      .chan_b_power_down_o(b_pd), .chan_a_ref_one_o(a_r1), .chan_b_ref_one_o(b_r1),
      .chan_a_clock_output_o(a_co), .chan_a_clock_output_oe_o(a_oe),
      .chan_b_clock_output_o(b_co), .chan_b_clock_output_oe_o(b_oe), .pat_en_o(pen),
      .pat_sel_o(pso), .pattern_check_ok_o(ok), .pattern_check_ok_oe_o(ok_oe));
   tccp_tick_src u_src (.core_clk_i(clk), .reset_n_i(rst_n), .byte_clk_tick_o(byt),
      .osc_clk_tick_o(osc));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk_eq(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk_eq
   task automatic wrap_up;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   // Cycles from one rising edge of the output clock to the next.
   task automatic period(output int n);
      n = 0;
      while (a_co !== 1'b0) step(1);
      while (a_co !== 1'b1) step(1);
      do begin step(1); n++; end while (a_co !== 1'b0);
      do begin step(1); n++; end while (a_co !== 1'b1);
   endtask : period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, a_rd, b_rd, rsel, a_rc, b_rc, dis, pte} = 8'h00;
      {a_sl, b_sl} = 2'h3;
      src = TCCP_SRC_BYTE;
      {dsel, psel, psi, ren, chk} = 32'h0;
      step(5);
      chk_eq({a_co, a_oe, b_co, b_oe, b_pd}, 5'h0B);
      chk_eq({ok, ok_oe, pen, pso}, 12'h400);
      step(5);
      rst_n = 1'b1;
      step(6);
      chk_eq(pso, TCCP_PAT_31);
      chk_eq({a_oe, a_r1, b_r1}, 3'h4);
      psi = 2'h2;
      step(3);
      chk_eq(pso, 2'h2);
      b_sl = 1'b0;
      step(6);
      chk_eq(b_pd, 1'b1);
      b_sl = 1'b1;
      step(6);
      chk_eq(b_pd, 1'b0);
      {a_sl, b_sl} = 2'h0;
      step(6);
      chk_eq({a_oe, b_oe, ok_oe}, 3'h0);
      {a_sl, b_sl, a_rd, b_rd} = 4'hF;
      step(6);
      chk_eq({a_oe, b_oe, ok_oe}, 3'h1);
      {a_rd, b_rd, rsel} = 3'h1;
      step(6);
      chk_eq({a_r1, b_r1}, 2'h3);
      {rsel, a_rc} = 2'h1;
      step(6);
      chk_eq({a_r1, b_r1}, 2'h2);
      {a_rc, b_rc} = 2'h1;
      step(6);
      chk_eq({a_r1, b_r1}, 2'h1);
      dis = 1'b1;
      step(3);
      chk_eq({a_oe, b_oe}, 2'h0);
      {dis, a_rd} = 2'h1;
      step(3);
      chk_eq({a_oe, b_oe}, 2'h3);
      a_rd = 1'b0;
      b_rc = 1'b0;
      ren[1].rx_en = 1'b1;
      step(6);
      chk_eq({pen[1].hs_rx, pen[1].ls_rx, pen[0]}, 6'h30);
      ren = 4'h0;
      pte = 1'b1;
      step(6);
      chk_eq({pen, ok}, 9'h1FF);
      chk[0].hs_err = 1'b1;
      step(3);
      chk_eq(ok, 1'b0);
      psel = 4'h4;
      step(3);
      chk_eq(ok, 1'b1);
      chk[0].ls_err[2] = 1'b1;
      psel = 4'hA;
      step(3);
      chk_eq(ok, 1'b0);
      psel = 4'hB;
      step(3);
      chk_eq(ok, 1'b1);
      pte = 1'b0;
      step(6);
      chk_eq({pen, ok}, 9'h000);
      for (int i = 0; i < 10; i++) begin
         dsel = i[3:0];
         step(60);
         period(p);
         chk_eq(16'(p), 16'(2 * ratios[i]));
         chk_eq(b_co, a_co);
      end
      src = TCCP_SRC_OSC;
      step(60);
      period(p);
      chk_eq(16'(p), 16'h6);
      wrap_up();
   end
endmodule : tccp_top_tb
